//--- uart_rx_interrupt_wakeup.v
// Purpose: Serial interrupt merge, receive error flags, address detect and pin wake-up
// Assumes: Avalon-MM slave with waitrequest, one clock clk_in at 125 MHz
// Notes on behaviour
// - Parity error flag set on wrong parity, only when parity check enabled.
// - Parity error stored with its word; cleared by any reset.
// - Six sources merge into one low-pulse module interrupt request.
// - Two transmit sources have own enables; receive sources other than address detect share one.
// - Address detect has no flag; raises interrupt on address word when enabled.
// - Clock off, wake and receive enables set: pin falling edge wakes, no flag.
// - Wake also needs mode, unit and receive path enables, else ignored.
// - Status flags read-only; only defined serial actions clear them.
// - Vectored only with global and module enables set and stack not full.
// - With address detect, receive interrupt only when top data bit is one or the word overruns.
// - Tested bit is ninth in nine-bit mode, eighth in eight-bit mode.
// - Without address detect, every received word requests a receive interrupt.
// - When the serial clock stops, the module halts and later resumes.
// - Idle or sleep during reception freezes the receiver until resumed.
// - Idle or sleep leaves status, control and data registers unchanged.
// - Serial data arriving during wake-up start-up is discarded.
// - With global or module enable clear, wake-up only wakes, no interrupt.
// - After pin wake-up, interrupt held back until start-up interval ends.
// - Overrun clears after status read then data read; receive-available once such reads empty the buffer.
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_defines.vh"
module uart_rx_interrupt_wakeup #(
    parameter STARTUP_COUNT = `STARTUP_CYCLES
) (
    input wire clk_in,
    input wire reset_in,
    input wire [2:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire shared_serial_pin_in,
    input wire uart_clock_source_on_in,
    input wire cpu_sleep_in,
    input wire stack_full_in,
    input wire rx_word_strobe_in,
    input wire [8:0] rx_word_data_in,
    input wire rx_parity_bit_in,
    input wire rx_framing_error_in,
    input wire rx_noise_in,
    input wire tx_empty_in,
    input wire tx_idle_in,
    output reg serial_module_interrupt_n_out,
    output reg interrupt_vector_out,
    output reg wake_out,
    output reg module_halt_out,
    output reg nine_bit_word_select_out,
    output reg parity_odd_out
);
    localparam BUF_W = 12;

    // Word length aware top data bit used for address detection
    function top_bit;
        input [8:0] data;
        input nine;
        begin
            top_bit = nine ? data[8] : data[7];
        end
    endfunction

    // High when the received parity does not match the selected type
    function parity_bad;
        input [8:0] data;
        input nine;
        input pbit;
        input odd;
        reg x;
        begin
            x = ^data[7:0] ^ (nine & data[8]) ^ pbit;
            parity_bad = odd ? ~x : x;
        end
    endfunction

    reg [`CONTROL_W-1:0] control_r;
    reg [1:0] irq_ctrl_r;
    reg overrun_r;
    reg status_armed_r;
    reg startup_active_r;
    reg [`STARTUP_CNT_W-1:0] startup_cnt_r;
    reg tx_empty_src_d_r;
    reg tx_idle_src_d_r;
    reg pending_r;
    reg pending_nxt;
    reg wake_pending_r;
    reg [31:0] read_mux;

    wire pin_fell;
    wire [BUF_W-1:0] buf_head;
    wire buf_not_empty;
    wire buf_overflow;
    wire [BUF_W-1:0] push_word;
    wire halted;
    wire word_accept;
    wire pop_data;
    wire status_read;
    wire wake_event;
    wire word_top;
    wire rx_event;
    wire addr_event;
    wire tx_empty_src;
    wire tx_idle_src;
    wire tx_event;
    wire enables_ok;
    wire fire;
    wire bus_write;
    wire bus_read;

    assign bus_write = avs_write_in & ~avs_waitrequest_out;
    assign bus_read = avs_read_in & ~avs_waitrequest_out;
    assign status_read = bus_read & (avs_address_in == `REG_IDX_STATUS);

    assign pop_data = bus_read & (avs_address_in == `REG_IDX_DATA) & status_armed_r;

    assign halted = ~uart_clock_source_on_in | cpu_sleep_in;

    assign word_accept = rx_word_strobe_in & ~halted & ~startup_active_r;

    assign push_word = {rx_noise_in, rx_framing_error_in,
        control_r[`CT_PARITY_EN] &
        parity_bad(rx_word_data_in, control_r[`CT_NINE_BIT], rx_parity_bit_in, control_r[`CT_PARITY_ODD]),
        rx_word_data_in};

    pin_sync3 u_pin_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(shared_serial_pin_in),
        .level_out(),
        .fell_out(pin_fell)
    );

    rx_word_buffer #(
        .WIDTH(BUF_W)
    ) u_rx_buffer (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .push_in(word_accept),
        .push_data_in(push_word),
        .pop_in(pop_data),
        .head_out(buf_head),
        .not_empty_out(buf_not_empty),
        .overflow_out(buf_overflow)
    );

    assign wake_event = pin_fell & ~uart_clock_source_on_in & control_r[`CT_WAKE_EN] & control_r[`CT_RX_IE] &
        control_r[`CT_MODE_SEL] & control_r[`CT_UNIT_EN] & control_r[`CT_RX_EN];

    assign word_top = top_bit(rx_word_data_in, control_r[`CT_NINE_BIT]);

    assign rx_event = control_r[`CT_RX_IE] & ((word_accept & (~control_r[`CT_ADDR_EN] | word_top)) |
        (word_accept & buf_overflow));

    assign addr_event = word_accept & control_r[`CT_ADDR_EN] & word_top;

    assign tx_empty_src = tx_empty_in & control_r[`CT_TX_EMPTY_IE];
    assign tx_idle_src = tx_idle_in & control_r[`CT_TX_IDLE_IE];
    assign tx_event = (tx_empty_src & ~tx_empty_src_d_r) | (tx_idle_src & ~tx_idle_src_d_r);

    assign enables_ok = irq_ctrl_r[`IC_GLOBAL_EN] & irq_ctrl_r[`IC_MODULE_EN];

    assign fire = pending_nxt & ~startup_active_r;

    always @* begin
        pending_nxt = pending_r | rx_event | addr_event | (tx_event & ~halted);
        if (wake_pending_r & enables_ok) begin
            pending_nxt = 1'b1;
        end
    end

    always @* begin
        read_mux = 32'h0000_0000;
        case (avs_address_in)
            `REG_IDX_STATUS: begin
                read_mux[`ST_PARITY_ERR] = buf_head[9];
                read_mux[`ST_FRAMING_ERR] = buf_head[10];
                read_mux[`ST_NOISE_ERR] = buf_head[11];
                read_mux[`ST_OVERRUN] = overrun_r;
                read_mux[`ST_RX_AVAIL] = buf_not_empty;
                read_mux[`ST_TX_EMPTY] = tx_empty_in;
                read_mux[`ST_TX_IDLE] = tx_idle_in;
                read_mux[`ST_STARTUP] = startup_active_r;
            end
            `REG_IDX_CONTROL: begin
                read_mux[`CONTROL_W-1:0] = control_r;
            end
            `REG_IDX_DATA: begin
                read_mux[8:0] = buf_head[8:0];
            end
            `REG_IDX_IRQ_CTRL: begin
                read_mux[1:0] = irq_ctrl_r;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    // Bus slave: one wait cycle, then the access completes
    always @(posedge clk_in) begin
        if (reset_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            if (~avs_waitrequest_out) begin
                avs_waitrequest_out <= 1'b1;
            end else if (avs_read_in | avs_write_in) begin
                avs_waitrequest_out <= 1'b0;
                avs_readdata_out <= avs_read_in ? read_mux : 32'h0000_0000;
            end
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            control_r <= `CONTROL_RESET;
            irq_ctrl_r <= `IRQ_CTRL_RESET;
        end else if (bus_write) begin
            if (avs_address_in == `REG_IDX_CONTROL) begin
                control_r <= avs_writedata_in[`CONTROL_W-1:0];
            end
            if (avs_address_in == `REG_IDX_IRQ_CTRL) begin
                irq_ctrl_r <= avs_writedata_in[1:0];
            end
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            overrun_r <= 1'b0;
            status_armed_r <= 1'b0;
        end else begin
            if (word_accept & buf_overflow) begin
                overrun_r <= 1'b1;
            end else if (pop_data) begin
                overrun_r <= 1'b0;
            end
            if (status_read) begin
                status_armed_r <= 1'b1;
            end else if (pop_data) begin
                status_armed_r <= 1'b0;
            end
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            startup_active_r <= 1'b0;
            startup_cnt_r <= {`STARTUP_CNT_W{1'b0}};
            wake_pending_r <= 1'b0;
        end else begin
            if (wake_event) begin
                startup_active_r <= 1'b1;
                startup_cnt_r <= STARTUP_COUNT[`STARTUP_CNT_W-1:0];
                wake_pending_r <= 1'b1;
            end else if (startup_active_r & uart_clock_source_on_in) begin
                if (startup_cnt_r <= {{(`STARTUP_CNT_W-1){1'b0}}, 1'b1}) begin
                    startup_active_r <= 1'b0;
                end
                startup_cnt_r <= startup_cnt_r - {{(`STARTUP_CNT_W-1){1'b0}}, 1'b1};
            end else if (~startup_active_r) begin
                wake_pending_r <= 1'b0;
            end
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            pending_r <= 1'b0;
            serial_module_interrupt_n_out <= 1'b1;
            interrupt_vector_out <= 1'b0;
            tx_empty_src_d_r <= 1'b0;
            tx_idle_src_d_r <= 1'b0;
        end else begin
            if (~halted) begin
                tx_empty_src_d_r <= tx_empty_src;
                tx_idle_src_d_r <= tx_idle_src;
            end
            pending_r <= pending_nxt & startup_active_r;
            serial_module_interrupt_n_out <= ~fire;
            interrupt_vector_out <= fire & enables_ok & ~stack_full_in;
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            wake_out <= 1'b0;
            module_halt_out <= 1'b1;
            nine_bit_word_select_out <= 1'b0;
            parity_odd_out <= 1'b0;
        end else begin
            wake_out <= wake_event;
            module_halt_out <= halted;
            nine_bit_word_select_out <= control_r[`CT_NINE_BIT];
            parity_odd_out <= control_r[`CT_PARITY_ODD];
        end
    end
endmodule
`default_nettype wire

//--- uart_irq_defines.vh
// Purpose: Shared constants for the serial interrupt and wake-up block
// Assumes: 125 MHz clk_in, Avalon-MM word addressing
// Notes: Byte address of a register is four times its index
`ifndef UART_IRQ_DEFINES_VH
`define UART_IRQ_DEFINES_VH

`define CLK_PERIOD_NS 8
`define STARTUP_TIME_NS 16000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_CNT_W 12

`define REG_IDX_STATUS 3'h0
`define REG_IDX_CONTROL 3'h1
`define REG_IDX_DATA 3'h2
`define REG_IDX_IRQ_CTRL 3'h3

`define ST_PARITY_ERR 0
`define ST_FRAMING_ERR 1
`define ST_NOISE_ERR 2
`define ST_OVERRUN 3
`define ST_RX_AVAIL 4
`define ST_TX_EMPTY 5
`define ST_TX_IDLE 6
`define ST_STARTUP 7

`define CT_TX_EMPTY_IE 0
`define CT_TX_IDLE_IE 1
`define CT_RX_IE 2
`define CT_ADDR_EN 3
`define CT_WAKE_EN 4
`define CT_PARITY_EN 5
`define CT_PARITY_ODD 6
`define CT_NINE_BIT 7
`define CT_MODE_SEL 8
`define CT_UNIT_EN 9
`define CT_RX_EN 10
`define CONTROL_W 11
`define CONTROL_RESET 11'h000

`define IC_GLOBAL_EN 0
`define IC_MODULE_EN 1
`define IRQ_CTRL_RESET 2'h0

`endif

//--- pin_sync3.v
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to clk_in
// Notes: Level follows only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
    input wire clk_in,
    input wire reset_in,
    input wire pin_in,
    output wire level_out,
    output wire fell_out
);
    reg level_r;
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg level_d_r;

    always @(posedge clk_in) begin
        if (reset_in) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level_r <= 1'b1;
            level_d_r <= 1'b1;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
            level_d_r <= level_r;
        end
    end

    assign fell_out = level_d_r & ~level_r;
    assign level_out = level_r;
endmodule
`default_nettype wire

//--- rx_word_buffer.v
// Purpose: Two-deep receive buffer holding each word with its error flags
// Assumes: Push and pop are single-cycle strobes
// Notes: A push into a full buffer with no pop in the same cycle is dropped and reported as overflow
`timescale 1ns/10ps
`default_nettype none
module rx_word_buffer #(
    parameter WIDTH = 12
) (
    input wire clk_in,
    input wire reset_in,
    input wire push_in,
    input wire [WIDTH-1:0] push_data_in,
    input wire pop_in,
    output wire [WIDTH-1:0] head_out,
    output wire not_empty_out,
    output wire overflow_out
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg rd_idx_r;
    reg wr_idx_r;
    reg [1:0] count_r;
    wire do_pop;
    wire do_push;

    assign do_pop = pop_in & (count_r != 2'h0);
    assign do_push = push_in & ((count_r != 2'h2) | do_pop);
    assign overflow_out = push_in & ~do_push;
    assign head_out = (count_r == 2'h0) ? {WIDTH{1'b0}} : mem_r[rd_idx_r];
    assign not_empty_out = (count_r != 2'h0);

    always @(posedge clk_in) begin
        if (reset_in) begin
            rd_idx_r <= 1'b0;
            wr_idx_r <= 1'b0;
            count_r <= 2'h0;
            mem_r[0] <= {WIDTH{1'b0}};
            mem_r[1] <= {WIDTH{1'b0}};
        end else begin
            if (do_push) begin
                mem_r[wr_idx_r] <= push_data_in;
                wr_idx_r <= ~wr_idx_r;
            end
            if (do_pop) begin
                rd_idx_r <= ~rd_idx_r;
            end
            if (do_push & ~do_pop) begin
                count_r <= count_r + 2'h1;
            end else if (do_pop & ~do_push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- uart_irq_checker_assertions.sv
// Purpose: Port-level checks for the serial interrupt and wake-up block
// Assumes: Control and enable bits are tracked from completed bus writes
// Notes: Receive-word checks stop after the first wake-up
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_defines.vh"
module uart_irq_checker #(
    parameter STARTUP_COUNT = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    input wire logic uart_clock_source_on_in,
    input wire logic cpu_sleep_in,
    input wire logic stack_full_in,
    input wire logic rx_word_strobe_in,
    input wire logic [8:0] rx_word_data_in,
    input wire logic serial_module_interrupt_n_out,
    input wire logic interrupt_vector_out,
    input wire logic wake_out,
    input wire logic module_halt_out
);
    reg [10:0] ctrl_r;
    reg [1:0] ic_r;
    reg woke_r;
    int su_r;
    wire wr_ok = avs_write_in && !avs_waitrequest_out;
    wire top = ctrl_r[`CT_NINE_BIT] ? rx_word_data_in[8] : rx_word_data_in[7];
    wire rx_go = rx_word_strobe_in && !module_halt_out && !woke_r;
    always @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r <= 11'h000;
            ic_r <= 2'h0;
            woke_r <= 1'b0;
            su_r <= 0;
        end else begin
            if (wr_ok && avs_address_in == `REG_IDX_CONTROL) ctrl_r <= avs_writedata_in[10:0];
            if (wr_ok && avs_address_in == `REG_IDX_IRQ_CTRL) ic_r <= avs_writedata_in[1:0];
            if (wake_out) begin
                woke_r <= 1'b1;
                su_r <= STARTUP_COUNT;
            end else if (uart_clock_source_on_in && su_r != 0) begin
                su_r <= su_r - 1;
            end
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
        !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("access not answered after one wait");
    AST_IRQ_ONE_CYCLE: assert property ($fell(serial_module_interrupt_n_out) |=> serial_module_interrupt_n_out)
        else $error("interrupt low longer than one cycle");
    AST_VECTOR_GATED: assert property (interrupt_vector_out |->
        !serial_module_interrupt_n_out && ic_r == 2'h3 && !$past(stack_full_in)) else $error("vector not gated");
    AST_RX_IRQ: assert property (rx_go && ctrl_r[`CT_RX_IE] && !ctrl_r[`CT_ADDR_EN] |=>
        !serial_module_interrupt_n_out) else $error("received word gave no interrupt");
    AST_ADDR_IRQ: assert property (rx_go && ctrl_r[`CT_ADDR_EN] && top |=> !serial_module_interrupt_n_out)
        else $error("address word gave no interrupt");
    AST_WAKE_QUAL: assert property (wake_out |-> $past(!uart_clock_source_on_in) &&
        ctrl_r[10:8] == 3'h7 && ctrl_r[`CT_WAKE_EN] && ctrl_r[`CT_RX_IE]) else $error("unqualified wake");
    AST_HALT: assert property (!$past(reset_in) |->
        module_halt_out == $past(!uart_clock_source_on_in || cpu_sleep_in)) else $error("halt wrong");
    AST_STARTUP_HOLD: assert property (su_r > 1 |-> serial_module_interrupt_n_out)
        else $error("interrupt during start-up");
    COV_WAKE: cover property (wake_out);
    COV_VECTOR: cover property (interrupt_vector_out);
    COV_ADDR: cover property (rx_go && ctrl_r[`CT_ADDR_EN]);
endmodule
bind uart_rx_interrupt_wakeup uart_irq_checker #(.STARTUP_COUNT(STARTUP_COUNT)) i_chk (.clk_in, .reset_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out,
    .uart_clock_source_on_in, .cpu_sleep_in, .stack_full_in, .rx_word_strobe_in, .rx_word_data_in,
    .serial_module_interrupt_n_out, .interrupt_vector_out, .wake_out, .module_halt_out);
`default_nettype wire

//--- serial_peer.sv
// Purpose: Far-side serial peer: drives the pin and hands over finished words
// Assumes: Called just after a rising clock edge
// Notes: Qualifiers show inverted values outside the strobe cycle
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    input wire logic clk_in,
    output logic pin_out,
    output logic strobe_out,
    output logic [8:0] data_out,
    output logic pbit_out,
    output logic ferr_out,
    output logic noise_out
);
    initial begin
        {pin_out, strobe_out, data_out, pbit_out, ferr_out, noise_out} = {1'b1, 1'b0, 9'h000, 3'h0};
    end
    task automatic send_word(input logic [8:0] d, input logic p);
        strobe_out <= 1'b1;
        data_out <= d;
        pbit_out <= p;
        {ferr_out, noise_out} <= 2'h0;
        @(posedge clk_in);
        strobe_out <= 1'b0;
        data_out <= ~d;
        pbit_out <= ~p;
        {ferr_out, noise_out} <= 2'h3;
    endtask
    // Start-bit edge then back to idle high
    task automatic fall_pin();
        pin_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        pin_out <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

//--- uart_rx_interrupt_wakeup_tb.sv
// Purpose: Self-checking bench for the serial interrupt and wake-up block
// Assumes: Short start-up count of 8 cycles
// Notes: Pulses are counted on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_defines.vh"
module uart_rx_interrupt_wakeup_tb;
    localparam int SU = 8;
    typedef struct packed {logic [10:0] ctrl; logic [8:0] d; logic p; logic irq; logic perr;} row_t;
    logic clk_in = 1'b0, reset_in = 1'b1, rd = 1'b0, wr = 1'b0, clk_on = 1'b1, sleep = 1'b0;
    logic stack_full = 1'b0, tx_empty = 1'b0, tx_idle = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [31:0] wdata = 32'h0, rdata;
    wire logic [31:0] rbus;
    wire logic waitreq, irq_n, vec, wake, halt, pin, stb, pb, fe, nz, nbs, podd;
    wire logic [8:0] wd;
    int n_fail = 0, total_checks = 0, n_irq = 0, n_vec = 0, n_wake = 0, cycles = 0, b, bv;
    row_t rows [11] = '{'{11'h004, 9'h0A5, 1'b0, 1'b1, 1'b0}, '{11'h024, 9'h0A5, 1'b1, 1'b1, 1'b1},
        '{11'h064, 9'h0A5, 1'b1, 1'b1, 1'b0}, '{11'h064, 9'h0A5, 1'b0, 1'b1, 1'b1},
        '{11'h004, 9'h0A5, 1'b1, 1'b1, 1'b0}, '{11'h00C, 9'h07F, 1'b0, 1'b0, 1'b0},
        '{11'h00C, 9'h080, 1'b0, 1'b1, 1'b0}, '{11'h08C, 9'h080, 1'b0, 1'b0, 1'b0},
        '{11'h08C, 9'h100, 1'b0, 1'b1, 1'b0}, '{11'h008, 9'h080, 1'b0, 1'b1, 1'b0},
        '{11'h000, 9'h0A5, 1'b0, 1'b0, 1'b0}};
    uart_rx_interrupt_wakeup #(.STARTUP_COUNT(SU)) i_dut (.clk_in(clk_in), .reset_in(reset_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_readdata_out(rbus), .avs_waitrequest_out(waitreq), .shared_serial_pin_in(pin),
        .uart_clock_source_on_in(clk_on), .cpu_sleep_in(sleep), .stack_full_in(stack_full),
        .rx_word_strobe_in(stb), .rx_word_data_in(wd), .rx_parity_bit_in(pb), .rx_framing_error_in(fe),
        .rx_noise_in(nz), .tx_empty_in(tx_empty), .tx_idle_in(tx_idle), .serial_module_interrupt_n_out(irq_n),
        .interrupt_vector_out(vec), .wake_out(wake), .module_halt_out(halt),
        .nine_bit_word_select_out(nbs), .parity_odd_out(podd));
    serial_peer i_peer (.clk_in(clk_in), .pin_out(pin), .strobe_out(stb), .data_out(wd), .pbit_out(pb),
        .ferr_out(fe), .noise_out(nz));
    always #4 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        cycles++;
        n_irq += (irq_n === 1'b0);
        n_vec += (vec === 1'b1);
        n_wake += (wake === 1'b1);
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_in);
        while (waitreq !== 1'b0) @(posedge clk_in);
        rdata = rbus;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic word(input logic [8:0] d);
        i_peer.send_word(d, 1'b0);
        repeat (3) @(posedge clk_in);
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        foreach (rows[i]) begin
            bus(1'b1, `REG_IDX_CONTROL, {21'h0, rows[i].ctrl});
            b = n_irq;
            i_peer.send_word(rows[i].d, rows[i].p);
            repeat (3) @(posedge clk_in);
            chk("irq", rows[i].irq, n_irq - b);
            chk("copies", {rows[i].ctrl[7], rows[i].ctrl[6]}, {nbs, podd});
            bus(1'b0, `REG_IDX_STATUS, 32'h0);
            chk("parity", rows[i].perr, rdata[`ST_PARITY_ERR]);
            bus(1'b0, `REG_IDX_DATA, 32'h0);
            chk("data", rows[i].d, rdata[8:0]);
        end
        bus(1'b1, `REG_IDX_CONTROL, 32'h24);
        bus(1'b1, `REG_IDX_IRQ_CTRL, 32'h3);
        i_peer.send_word(9'h0A5, 1'b1);
        reset_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("status", 32'h0, rdata);
        bus(1'b0, `REG_IDX_CONTROL, 32'h0);
        chk("control", 32'h0, rdata);
        bus(1'b0, `REG_IDX_IRQ_CTRL, 32'h0);
        chk("irq ctrl", 32'h0, rdata);
        bus(1'b1, `REG_IDX_STATUS, 32'hFFFFFFFF);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("status write", 32'h0, rdata);
        bus(1'b0, 3'h5, 32'h0);
        chk("unmapped", 32'h0, rdata);
        // Consume the arm left by the status reads above
        bus(1'b0, `REG_IDX_DATA, 32'h0);
        chk("empty data", 32'h0, rdata);
        word(9'h033);
        bus(1'b0, `REG_IDX_DATA, 32'h0);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("avail kept", 1'b1, rdata[`ST_RX_AVAIL]);
        bus(1'b0, `REG_IDX_DATA, 32'h0);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("avail clear", 1'b0, rdata[`ST_RX_AVAIL]);
        bus(1'b1, `REG_IDX_CONTROL, 32'h4);
        word(9'h011);
        word(9'h022);
        word(9'h044);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("overrun", 2'h3, rdata[4:3]);
        bus(1'b0, `REG_IDX_DATA, 32'h0);
        chk("first kept", 9'h011, rdata[8:0]);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("overrun clear", 2'h2, rdata[4:3]);
        bus(1'b0, `REG_IDX_DATA, 32'h0);
        chk("second kept", 9'h022, rdata[8:0]);
        bus(1'b1, `REG_IDX_CONTROL, 32'h1);
        b = n_irq;
        tx_empty <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("tx empty irq", 1, n_irq - b);
        tx_idle <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("tx idle masked", 1, n_irq - b);
        {tx_empty, tx_idle} <= 2'h0;
        bus(1'b1, `REG_IDX_CONTROL, 32'h4);
        bus(1'b1, `REG_IDX_IRQ_CTRL, 32'h3);
        b = n_vec;
        word(9'h055);
        chk("vector", 1, n_vec - b);
        stack_full <= 1'b1;
        b = n_irq;
        bv = n_vec;
        word(9'h066);
        chk("vector stack full", 0, n_vec - bv);
        chk("irq stack full", 1, n_irq - b);
        stack_full <= 1'b0;
        repeat (2) begin
            bus(1'b0, `REG_IDX_STATUS, 32'h0);
            bus(1'b0, `REG_IDX_DATA, 32'h0);
        end
        clk_on <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk("halt", 1'b1, halt);
        word(9'h077);
        clk_on <= 1'b1;
        sleep <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("halt sleep", 1'b1, halt);
        sleep <= 1'b0;
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("halted word", 1'b0, rdata[`ST_RX_AVAIL]);
        bus(1'b1, `REG_IDX_IRQ_CTRL, 32'h0);
        bus(1'b1, `REG_IDX_CONTROL, 32'h614);
        clk_on <= 1'b0;
        b = n_wake;
        i_peer.fall_pin();
        chk("wake", 0, n_wake - b);
        bus(1'b1, `REG_IDX_CONTROL, 32'h714);
        i_peer.fall_pin();
        chk("wake", 1, n_wake - b);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("startup", 1'b1, rdata[`ST_STARTUP]);
        b = n_irq;
        clk_on <= 1'b1;
        repeat (SU + 6) @(posedge clk_in);
        chk("wake no irq", 0, n_irq - b);
        bus(1'b1, `REG_IDX_IRQ_CTRL, 32'h3);
        clk_on <= 1'b0;
        i_peer.fall_pin();
        b = n_irq;
        clk_on <= 1'b1;
        i_peer.send_word(9'h0A5, 1'b0);
        repeat (SU - 3) @(posedge clk_in);
        chk("irq held", 0, n_irq - b);
        repeat (8) @(posedge clk_in);
        chk("wake irq", 1, n_irq - b);
        bus(1'b0, `REG_IDX_STATUS, 32'h0);
        chk("startup word", 2'h0, {rdata[`ST_STARTUP], rdata[`ST_RX_AVAIL]});
        end_of_test();
    end
endmodule
`default_nettype wire
